// [inc/ocp_defines.vh]
// Purpose: shared constants of the output compare block
// Assumes: 32-bit Avalon-MM word addressing, 16-bit registers
// Notes: definitions only
`ifndef OCP_DEFINES_VH
`define OCP_DEFINES_VH

`define OCP_NUM_CH 8
`define OCP_AW 6

// Per channel word offsets, channel base is 4 * channel
`define OCP_OFS_SEC 2'h0
`define OCP_OFS_PRI 2'h1
`define OCP_OFS_CTL 2'h2

// Timer and shared words
`define OCP_ADR_TCON_A 6'h20
`define OCP_ADR_PER_A 6'h21
`define OCP_ADR_CNT_A 6'h22
`define OCP_ADR_TCON_B 6'h24
`define OCP_ADR_PER_B 6'h25
`define OCP_ADR_CNT_B 6'h26
`define OCP_ADR_FLAGS 6'h28
`define OCP_ADR_IEN 6'h29

// Channel control fields
`define OCP_CTL_TSEL 3
`define OCP_CTL_FAULT 4
`define OCP_CTL_SIDL 13
`define OCP_CTL_WMASK 16'h200f
`define OCP_CTL_RST 16'h0000

// Timer control fields
`define OCP_TCON_ON 15
`define OCP_TCON_TIMER_IDLE_STOP 13
`define OCP_TCON_WMASK 16'ha030
`define OCP_TCON_RST 16'h0000
`define OCP_PER_RST 16'hffff

// Mode encodings
`define OCP_MODE_OFF 3'h0
`define OCP_MODE_LOW 3'h1
`define OCP_MODE_HIGH 3'h2
`define OCP_MODE_TOG 3'h3
`define OCP_MODE_SINGLE 3'h4
`define OCP_MODE_CONT 3'h5
`define OCP_MODE_PWM 3'h6
`define OCP_MODE_PWMF 3'h7

// Prescale terminal counts for 1, 8, 64, 256
`define OCP_PRE_1 8'h00
`define OCP_PRE_8 8'h07
`define OCP_PRE_64 8'h3f
`define OCP_PRE_256 8'hff

`endif

// [logic/ocp_channel.v]
// Purpose: one compare channel, pin state and duty latch
// Assumes: tick, next count and wrap come from the selected timer
// Notes: mode_wr_i arrives in the same cycle as the changed mode field
`timescale 1ns/1ps
`include "ocp_defines.vh"

module ocp_channel (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire run_i,
    input wire tick_i,
    input wire wrap_i,
    input wire [15:0] nxt_i,
    input wire pri_wr_i,
    input wire [15:0] pri_wdata_i,
    input wire [15:0] sec_i,
    input wire [2:0] mode_i,
    input wire mode_wr_i,
    input wire fault_ok_i,
    output reg pin_o,
    output reg oe_n_o,
    output reg evt_o,
    output reg fault_o,
    output reg [15:0] pri_o
);

    reg armed_reg;
    wire pwm = mode_i[2] & mode_i[1];
    wire go = run_i & tick_i;
    wire hit_p = go & (nxt_i == pri_o);
    wire hit_s = go & (nxt_i == sec_i);
    // Fault set wins over a rewrite that lands in the same cycle
    wire fault_set = (mode_i == `OCP_MODE_PWMF) & ~fault_ok_i;
    wire fault_clr = mode_wr_i & fault_ok_i;
    wire fault_next = fault_set | (fault_o & ~fault_clr);

    // Compare actions; no wrap test needed, a missed match changes nothing
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pin_o <= 1'b0;
            oe_n_o <= 1'b0;
            evt_o <= 1'b0;
            fault_o <= 1'b0;
            pri_o <= 16'h0000;
            armed_reg <= 1'b0;
        end else begin
            evt_o <= 1'b0;
            fault_o <= fault_next;
            oe_n_o <= fault_next;
            if (pri_wr_i && !pwm) begin
                pri_o <= pri_wdata_i;
            end
            case (mode_i)
                `OCP_MODE_LOW: begin
                    if (hit_p) begin
                        pin_o <= 1'b0;
                        evt_o <= 1'b1;
                    end
                end
                `OCP_MODE_HIGH: begin
                    if (hit_p) begin
                        pin_o <= 1'b1;
                        evt_o <= 1'b1;
                    end
                end
                `OCP_MODE_TOG: begin
                    if (hit_p) begin
                        pin_o <= ~pin_o;
                        evt_o <= 1'b1;
                    end
                end
                `OCP_MODE_SINGLE, `OCP_MODE_CONT: begin
                    if (armed_reg || mode_i == `OCP_MODE_CONT) begin
                        if (hit_p) begin
                            pin_o <= 1'b1;
                        end
                        if (hit_s) begin
                            pin_o <= 1'b0;
                        end
                        evt_o <= hit_p | hit_s;
                    end
                    // Disarm only once the pulse was driven high
                    if (hit_s && pin_o && mode_i == `OCP_MODE_SINGLE) begin
                        armed_reg <= 1'b0;
                    end
                end
                `OCP_MODE_PWM, `OCP_MODE_PWMF: begin
                    // No compare event here, only the timer flag rises
                    if (go && wrap_i) begin
                        pri_o <= sec_i;
                        pin_o <= (sec_i != 16'h0000);
                    end else if (hit_p) begin
                        pin_o <= 1'b0;
                    end
                end
                default: begin
                    pin_o <= pin_o;
                end
            endcase
            // Every rewrite to single pulse arms one new pulse
            if (mode_wr_i) begin
                armed_reg <= (mode_i == `OCP_MODE_SINGLE);
            end
        end
    end

endmodule

// [logic/ocp_top.v]
// Purpose: output compare block, eight channels, two timers, Avalon slave
// Assumes: clk_sys_i is the instruction clock, one timer step per clock at prescale 1
// Notes: sleep_i and idle_i come from logic on the same clock
`timescale 1ns/1ps
`include "ocp_defines.vh"

module ocp_top (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [5:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    input wire fault_n_i,
    input wire sleep_i,
    input wire idle_i,
    output wire [7:0] oc_pin_o,
    output wire [7:0] oc_pin_oe_n_o,
    output reg [7:0] cmp_irq_o,
    output reg [1:0] tmr_irq_o
);

    // Byte lane merge of a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0] be;
        begin
            merge16 = {be[1] ? nw[15:8] : old[15:8],
                       be[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    // Prescale terminal count from the two select bits
    function [7:0] pre_max;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: pre_max = `OCP_PRE_1;
                2'h1: pre_max = `OCP_PRE_8;
                2'h2: pre_max = `OCP_PRE_64;
                default: pre_max = `OCP_PRE_256;
            endcase
        end
    endfunction

    reg [15:0] sec_reg [0:7];
    reg [15:0] ctl_reg [0:7];
    reg [15:0] tcon_reg [0:1];
    reg [15:0] per_reg [0:1];
    reg [15:0] cnt_reg [0:1];
    reg [7:0] pre_reg [0:1];
    reg [9:0] flag_reg;
    reg [9:0] ien_reg;
    reg [7:0] mode_wr_reg;
    reg fault_s1_reg;
    reg fault_s2_reg;
    reg [31:0] rdata_next;
    wire [15:0] pri_w [0:7];
    wire [7:0] fault_w;
    wire [7:0] evt_w;
    wire [15:0] tnxt [0:1];
    wire [1:0] ttick;
    wire [1:0] twrap;
    wire [1:0] trun;
    integer k;

    // Avalon handshake: wait one cycle, then answer
    wire ack = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    wire wr_ack = avs_write_i & ~avs_waitrequest_o;
    wire [15:0] wd16 = avs_writedata_i[15:0];
    wire [1:0] be16 = avs_byteenable_i[1:0];
    wire is_ch = ~avs_address_i[5];
    wire [2:0] ch_sel = avs_address_i[4:2];
    wire [1:0] ch_ofs = avs_address_i[1:0];
    wire [15:0] ien_wr = merge16({6'h00, ien_reg}, wd16, be16);

    // Fault pin passes two flip-flops before use
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            fault_s1_reg <= 1'b1;
            fault_s2_reg <= 1'b1;
        end else begin
            fault_s1_reg <= fault_n_i;
            fault_s2_reg <= fault_s1_reg;
        end
    end

    // Timer stepping: one step per clock, divided by prescale
    genvar t;
    generate
        for (t = 0; t < 2; t = t + 1) begin : g_tmr
            assign trun[t] = ~sleep_i
                & ~(idle_i & tcon_reg[t][`OCP_TCON_TIMER_IDLE_STOP]);
            assign ttick[t] = trun[t] & tcon_reg[t][`OCP_TCON_ON]
                & (pre_reg[t] == pre_max(tcon_reg[t][5:4]));
            assign twrap[t] = cnt_reg[t] == per_reg[t];
            assign tnxt[t] = twrap[t] ? 16'h0000
                : cnt_reg[t] + 16'h0001;
        end
    endgenerate

    // Channel replicas with their own timer selection
    genvar i;
    generate
        for (i = 0; i < `OCP_NUM_CH; i = i + 1) begin : g_ch
            wire s = ctl_reg[i][`OCP_CTL_TSEL];
            wire hit = wr_ack & is_ch & (ch_sel == i);
            wire run_c = ~sleep_i & ~(idle_i & (ctl_reg[i][`OCP_CTL_SIDL]
                | ~tcon_reg[s][`OCP_TCON_ON]
                | tcon_reg[s][`OCP_TCON_TIMER_IDLE_STOP]));
            ocp_channel u_ch (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n_i),
                .run_i(run_c),
                .tick_i(ttick[s]),
                .wrap_i(twrap[s]),
                .nxt_i(tnxt[s]),
                .pri_wr_i(hit & (ch_ofs == `OCP_OFS_PRI)),
                .pri_wdata_i(merge16(pri_w[i], wd16, be16)),
                .sec_i(sec_reg[i]),
                .mode_i(ctl_reg[i][2:0]),
                .mode_wr_i(mode_wr_reg[i]),
                .fault_ok_i(fault_s2_reg),
                .pin_o(oc_pin_o[i]),
                .oe_n_o(oc_pin_oe_n_o[i]),
                .evt_o(evt_w[i]),
                .fault_o(fault_w[i]),
                .pri_o(pri_w[i])
            );
        end
    endgenerate

    // Register writes and timer counting share one process
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            for (k = 0; k < `OCP_NUM_CH; k = k + 1) begin
                sec_reg[k] <= 16'h0000;
                ctl_reg[k] <= `OCP_CTL_RST;
            end
            for (k = 0; k < 2; k = k + 1) begin
                tcon_reg[k] <= `OCP_TCON_RST;
                per_reg[k] <= `OCP_PER_RST;
                cnt_reg[k] <= 16'h0000;
                pre_reg[k] <= 8'h00;
            end
            mode_wr_reg <= 8'h00;
            ien_reg <= 10'h000;
        end else begin
            mode_wr_reg <= 8'h00;
            for (k = 0; k < 2; k = k + 1) begin
                if (ttick[k]) begin
                    pre_reg[k] <= 8'h00;
                    cnt_reg[k] <= tnxt[k];
                end else if (tcon_reg[k][`OCP_TCON_ON] && trun[k]) begin
                    // Prescaler halts with the timer, no late first step
                    pre_reg[k] <= pre_reg[k] + 8'h01;
                end
            end
            if (wr_ack && is_ch) begin
                case (ch_ofs)
                    `OCP_OFS_SEC: sec_reg[ch_sel] <=
                        merge16(sec_reg[ch_sel], wd16, be16);
                    `OCP_OFS_CTL: begin
                        ctl_reg[ch_sel] <= merge16(ctl_reg[ch_sel], wd16,
                            be16) & `OCP_CTL_WMASK;
                        // Pulse registered on the same edge as the field, so new mode seen
                        mode_wr_reg[ch_sel] <= be16[0];
                    end
                    default: begin
                    end
                endcase
            end
            if (wr_ack && !is_ch) begin
                case (avs_address_i)
                    `OCP_ADR_TCON_A: tcon_reg[0] <= merge16(tcon_reg[0],
                        wd16, be16) & `OCP_TCON_WMASK;
                    `OCP_ADR_TCON_B: tcon_reg[1] <= merge16(tcon_reg[1],
                        wd16, be16) & `OCP_TCON_WMASK;
                    `OCP_ADR_PER_A: per_reg[0] <=
                        merge16(per_reg[0], wd16, be16);
                    `OCP_ADR_PER_B: per_reg[1] <=
                        merge16(per_reg[1], wd16, be16);
                    `OCP_ADR_CNT_A: cnt_reg[0] <=
                        merge16(cnt_reg[0], wd16, be16);
                    `OCP_ADR_CNT_B: cnt_reg[1] <=
                        merge16(cnt_reg[1], wd16, be16);
                    `OCP_ADR_IEN: ien_reg <= ien_wr[9:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Sticky flags: write one clears, a new event wins
    wire flag_wr = wr_ack & (avs_address_i == `OCP_ADR_FLAGS);
    wire [15:0] clr_wr = merge16(16'h0000, wd16, be16);
    wire [9:0] flag_clr = flag_wr ? clr_wr[9:0] : 10'h000;
    wire [9:0] flag_set = {ttick & twrap, evt_w};
    wire [9:0] flag_next = flag_set | (flag_reg & ~flag_clr);
    wire [9:0] irq_next = flag_next & ien_reg;

    // Flags and gated request lines, all registered
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            flag_reg <= 10'h000;
            cmp_irq_o <= 8'h00;
            tmr_irq_o <= 2'h0;
        end else begin
            flag_reg <= flag_next;
            cmp_irq_o <= irq_next[7:0];
            tmr_irq_o <= irq_next[9:8];
        end
    end

    // Read mux; unmapped words read zero
    always @* begin
        rdata_next = 32'h00000000;
        if (is_ch) begin
            case (ch_ofs)
                `OCP_OFS_SEC: rdata_next[15:0] = sec_reg[ch_sel];
                `OCP_OFS_PRI: rdata_next[15:0] = pri_w[ch_sel];
                `OCP_OFS_CTL: begin
                    rdata_next[15:0] = ctl_reg[ch_sel];
                    rdata_next[`OCP_CTL_FAULT] = fault_w[ch_sel];
                end
                default: rdata_next = 32'h00000000;
            endcase
        end else begin
            case (avs_address_i)
                `OCP_ADR_TCON_A: rdata_next[15:0] = tcon_reg[0];
                `OCP_ADR_TCON_B: rdata_next[15:0] = tcon_reg[1];
                `OCP_ADR_PER_A: rdata_next[15:0] = per_reg[0];
                `OCP_ADR_PER_B: rdata_next[15:0] = per_reg[1];
                `OCP_ADR_CNT_A: rdata_next[15:0] = cnt_reg[0];
                `OCP_ADR_CNT_B: rdata_next[15:0] = cnt_reg[1];
                `OCP_ADR_FLAGS: rdata_next[9:0] = flag_reg;
                `OCP_ADR_IEN: rdata_next[9:0] = ien_reg;
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    // Waitrequest drops for one cycle per request; data set beforehand
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
        end else begin
            if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b0;
                if (avs_read_i) begin
                    avs_readdata_o <= rdata_next;
                end
            end else begin
                avs_waitrequest_o <= 1'b1;
            end
            if (ack) begin
                avs_readdata_o <= avs_readdata_o;
            end
        end
    end

endmodule

// [logic/ocp_pad_unused.v]
`timescale 1ns/1ps
// Purpose: none
// Assumes: none
// Notes: intentionally empty helper, no module

// [test/ocp_assertions.sv]
// Purpose: port level checks of the output compare block
// Assumes: one clock, synchronous active low reset
// Notes: fault sync latency taken as two to four edges
`timescale 1ns/1ps

module ocp_chk (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire fault_n_i,
    input wire sleep_i,
    input wire [7:0] oc_pin_o,
    input wire [7:0] oc_pin_oe_n_o,
    input wire [7:0] cmp_irq_o,
    input wire [1:0] tmr_irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    // Bus answers with exactly one wait cycle
    bus_take_a: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no accept");
    bus_release_a: assert property (!avs_waitrequest_o |=>
        avs_waitrequest_o) else $error("wait low too long");
    bus_idle_a: assert property (!avs_read_i && !avs_write_i |=>
        avs_waitrequest_o) else $error("accept without request");
    read_upper_a: assert property (avs_readdata_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    // Pin floats only after the fault line went low
    fault_float_a: assert property ($rose(|oc_pin_oe_n_o) |->
        !$past(fault_n_i, 2) || !$past(fault_n_i, 3) ||
        !$past(fault_n_i, 4)) else $error("float without fault");
    // Leaving shutdown needs fault gone and a mode rewrite
    fault_exit_a: assert property ($fell(|oc_pin_oe_n_o) |->
        $past(fault_n_i, 3) && ($past(avs_write_i, 2) ||
        $past(avs_write_i, 3) || $past(avs_write_i, 4)))
        else $error("shutdown left early");
    sleep_pin_a: assert property (sleep_i |=> $stable(oc_pin_o) &&
        $stable(oc_pin_oe_n_o)) else $error("pin moved in sleep");
    // Flag pipeline drains within two cycles, then irqs freeze
    sleep_irq_a: assert property (sleep_i [*3] |=>
        $stable(cmp_irq_o) && $stable(tmr_irq_o))
        else $error("irq moved in sleep");
endmodule

// [test/ocp_load_model.sv]
// Purpose: external load on the compare pins with a fault source
// Assumes: pins have pull-downs on the board
// Notes: fault line is registered, so it moves one edge after a request
`timescale 1ns/1ps

module ocp_load_model (
    input wire clk_sys_i,
    input wire [7:0] pin_i,
    input wire [7:0] oe_n_i,
    input wire fault_req_i,
    output wire [7:0] line_o,
    output logic fault_n_o
);
    // Floating pin reads as the pull-down level
    assign line_o = pin_i & ~oe_n_i;

    // Load pulls its fault line low while faulted
    initial fault_n_o = 1'b1;
    always @(posedge clk_sys_i) begin
        fault_n_o <= !fault_req_i;
    end
endmodule

// [test/ocp_top_bench.sv]
// Purpose: self-checking bench of the compare block
// Assumes: one timer step per clock at prescale 1
// Notes: expectations come from counts computed here
`timescale 1ns/1ps

module ocp_top_bench;
    logic clk_sys_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
    logic sleep_i = 0, idle_i = 0, fault_req = 0, c;
    logic [5:0] avs_address_i = 0;
    logic [31:0] avs_writedata_i = 0, r;
    logic [3:0] avs_byteenable_i = 4'hf;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o, fault_n_i;
    wire [7:0] oc_pin_o, oc_pin_oe_n_o, cmp_irq_o, line;
    wire [1:0] tmr_irq_o;
    int miscompares = 0, total_checks = 0, n, a, b, d;

    initial forever #12.5 clk_sys_i = ~clk_sys_i;

    ocp_top i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .fault_n_i(fault_n_i),
        .sleep_i(sleep_i), .idle_i(idle_i), .oc_pin_o(oc_pin_o),
        .oc_pin_oe_n_o(oc_pin_oe_n_o), .cmp_irq_o(cmp_irq_o),
        .tmr_irq_o(tmr_irq_o));
    ocp_load_model i_load (.clk_sys_i(clk_sys_i), .pin_i(oc_pin_o),
        .oe_n_i(oc_pin_oe_n_o), .fault_req_i(fault_req), .line_o(line),
        .fault_n_o(fault_n_i));

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask

    // One Avalon transfer; holds everything until waitrequest low
    task bus(input logic w, input logic [5:0] ad, input logic [15:0] wd);
        int k;
        @(posedge clk_sys_i);
        avs_address_i <= ad;
        avs_writedata_i <= {16'h0000, wd};
        avs_write_i <= w;
        avs_read_i <= !w;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 50);
        r = avs_readdata_o;
        avs_read_i <= 0;
        avs_write_i <= 0;
        if (k >= 50) begin
            miscompares++;
            close_out;
        end
    endtask

    // Cycles until a pin line reaches a level, bounded
    task wl(input int ch, input logic lv, output int t);
        t = 0;
        #1;
        while (line[ch] !== lv && t < 600) begin
            @(posedge clk_sys_i);
            #1;
            t++;
        end
        if (t >= 600) begin
            miscompares++;
            close_out;
        end
    endtask

    initial begin
        void'($urandom(75074));
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1;
        bus(0, 6'h02, 0);
        chk(r, 0);
        bus(0, 6'h21, 0);
        chk(r, 32'hffff);
        bus(0, 6'h3f, 0);
        chk(r, 0);
        bus(1, 6'h06, 16'hffff);
        bus(0, 6'h06, 0);
        chk(r, 32'h200f);
        // Single compare modes; ch3 value beyond the period, ch7 off
        // Mode before primary: ch1 leaves PWM first, so its primary write lands
        bus(1, 6'h21, 20);
        bus(1, 6'h01, 5);
        bus(1, 6'h02, 1);
        bus(1, 6'h06, 2);
        bus(1, 6'h05, 7);
        bus(1, 6'h09, 9);
        bus(1, 6'h0a, 3);
        bus(1, 6'h0d, 30);
        bus(1, 6'h0e, 3);
        bus(1, 6'h1d, 4);
        bus(1, 6'h29, 16'h0002);
        bus(1, 6'h20, 16'h8000);
        repeat (60) @(posedge clk_sys_i);
        bus(1, 6'h20, 0);
        chk(line[1], 1);
        chk(line[3], 0);
        chk(line[7], 0);
        bus(0, 6'h28, 0);
        chk(r[7:0], 8'h07);
        chk(cmp_irq_o, 8'h02);
        bus(1, 6'h28, 16'h03ff);
        bus(0, 6'h28, 0);
        chk(r, 0);
        // Dual compare pulses on timer A, period 10
        bus(1, 6'h21, 10);
        bus(1, 6'h22, 0);
        bus(1, 6'h10, 6);
        bus(1, 6'h11, 3);
        bus(1, 6'h12, 4);
        bus(1, 6'h14, 5);
        bus(1, 6'h15, 2);
        bus(1, 6'h16, 5);
        bus(1, 6'h20, 16'h8000);
        wl(4, 1, n);
        wl(4, 0, n);
        chk(n, 3);
        wl(5, 1, n);
        wl(5, 0, a);
        wl(5, 1, b);
        chk(a, 3);
        chk(a + b, 11);
        c = 0;
        repeat (30) begin
            @(posedge clk_sys_i);
            #1;
            c = c | line[4];
        end
        chk(c, 0);
        bus(1, 6'h12, 4);
        wl(4, 1, n);
        wl(4, 0, n);
        chk(n, 3);
        // Sleep with the continuous pulse high
        wl(5, 1, n);
        @(posedge clk_sys_i);
        sleep_i <= 1;
        repeat (20) @(posedge clk_sys_i);
        chk(line[5], 1);
        sleep_i <= 0;
        wl(5, 0, n);
        chk(n < 4, 1);
        // Idle stops timer A only while its idle bit is set
        bus(1, 6'h20, 16'ha000);
        idle_i <= 1;
        bus(0, 6'h22, 0);
        a = r;
        repeat (5) @(posedge clk_sys_i);
        bus(0, 6'h22, 0);
        chk(r, a);
        bus(1, 6'h20, 16'h8000);
        bus(0, 6'h22, 0);
        a = r;
        bus(0, 6'h22, 0);
        chk(r !== a, 1);
        idle_i <= 0;
        // PWM on timer B, random duty within the period
        d = 1 + $urandom % 15;
        bus(1, 6'h25, 15);
        bus(1, 6'h18, d[15:0]);
        bus(1, 6'h1a, 16'h000e);
        bus(1, 6'h24, 16'h8000);
        wl(6, 1, n);
        wl(6, 0, a);
        wl(6, 1, b);
        chk(a, d);
        chk(a + b, 16);
        bus(0, 6'h19, 0);
        chk(r, d);
        bus(1, 6'h19, 16'h1234);
        bus(0, 6'h19, 0);
        chk(r, d);
        bus(0, 6'h28, 0);
        chk(r[9], 1);
        chk(r[6], 0);
        // Timer B period flag reaches its request line once enabled
        bus(1, 6'h29, 16'h0200);
        repeat (2) @(posedge clk_sys_i);
        chk(tmr_irq_o, 2'h2);
        bus(1, 6'h18, 0);
        repeat (40) @(posedge clk_sys_i);
        c = 0;
        repeat (16) begin
            @(posedge clk_sys_i);
            #1;
            c = c | line[6];
        end
        chk(c, 0);
        bus(1, 6'h18, 16);
        repeat (40) @(posedge clk_sys_i);
        c = 1;
        repeat (16) begin
            @(posedge clk_sys_i);
            #1;
            c = c & line[6];
        end
        chk(c, 1);
        // Fault shutdown on ch7 needs both release and rewrite
        bus(1, 6'h1c, 5);
        bus(1, 6'h1e, 16'h000f);
        fault_req <= 1;
        repeat (6) @(posedge clk_sys_i);
        chk(oc_pin_oe_n_o[7], 1);
        chk(line[7], 0);
        chk(oc_pin_oe_n_o[6], 0);
        bus(0, 6'h1e, 0);
        chk(r[4], 1);
        bus(1, 6'h1e, 16'h000f);
        repeat (4) @(posedge clk_sys_i);
        chk(oc_pin_oe_n_o[7], 1);
        fault_req <= 0;
        repeat (6) @(posedge clk_sys_i);
        chk(oc_pin_oe_n_o[7], 1);
        bus(1, 6'h1e, 16'h000f);
        repeat (4) @(posedge clk_sys_i);
        chk(oc_pin_oe_n_o[7], 0);
        bus(0, 6'h1e, 0);
        chk(r[4], 0);
        close_out;
    end

    // Guard against a hang anywhere in the sequence
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        miscompares++;
        close_out;
    end
endmodule

bind ocp_top ocp_chk i_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .fault_n_i(fault_n_i), .sleep_i(sleep_i), .oc_pin_o(oc_pin_o),
    .oc_pin_oe_n_o(oc_pin_oe_n_o), .cmp_irq_o(cmp_irq_o),
    .tmr_irq_o(tmr_irq_o));
